// ===== logic/pxa_access.sv
// Serial target access logic of the port expander, both banks.
// Assumes bus pins and port pins are asynchronous to clk (50 MHz).
`include "pxa_defs.svh"
module pxa_access import pxa_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [3:0] addr_low,
  input wire logic [3:0] sense_inputs,
  input wire logic [3:0] mixed_out_sense,
  input wire logic [7:0] output_bank_sense,
  output logic mixed_bank_out_0,
  output logic mixed_bank_out_1,
  output logic mixed_bank_out_6,
  output logic mixed_bank_out_7,
  output logic [7:0] output_bank_pins,
  output logic [3:0] irq_mask,
  output logic alert_out,
  output logic alert_oe_n
);
  // Place readback and inputs at their pin positions
  function automatic logic [7:0] build_mixed(input logic [3:0] rb,
                                             input logic [3:0] ins);
    build_mixed = {rb[3], rb[2], ins, rb[1], rb[0]}; // [R19]
  endfunction

  // Two-stage synchronisers and one delay stage for edges
  pxa_bus_t bus_m, bus_s, bus_d;
  logic [3:0] sense_m, sense_s, mixrb_m, mixrb_s, addr_m, addr_s;
  logic [7:0] outrb_m, outrb_s;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_m <= '1;
      bus_s <= '1;
      bus_d <= '1;
      sense_m <= '0;
      sense_s <= '0;
      mixrb_m <= '0;
      mixrb_s <= '0;
      outrb_m <= '0;
      outrb_s <= '0;
      addr_m <= '0;
      addr_s <= '0;
    end else begin
      bus_m <= '{scl: scl, sda: sda_in};
      bus_s <= bus_m;
      bus_d <= bus_s;
      sense_m <= sense_inputs;
      sense_s <= sense_m;
      mixrb_m <= mixed_out_sense;
      mixrb_s <= mixrb_m;
      outrb_m <= output_bank_sense;
      outrb_s <= outrb_m;
      addr_m <= addr_low;
      addr_s <= addr_m;
    end
  end

  // Bus events seen from the synchronised lines
  logic scl_rise, scl_fall, start_det, stop_det, sda_s;
  assign sda_s = bus_s.sda;
  assign scl_rise = bus_s.scl & ~bus_d.scl;
  assign scl_fall = ~bus_s.scl & bus_d.scl;
  assign start_det = bus_s.scl & bus_d.scl & bus_d.sda & ~bus_s.sda;
  assign stop_det = bus_s.scl & bus_d.scl & ~bus_d.sda & bus_s.sda;

  pxa_state_t st, next_st;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic is_read, next_is_read, to_mixed, next_to_mixed;
  logic byte_sel, next_byte_sel, in_read, next_in_read;
  logic pending, next_pending, next_sda_oe_n, next_alert_oe_n;
  logic [3:0] flags, next_flags, ref_in, next_ref_in;
  logic [3:0] snap_flags, next_snap_flags, next_irq_mask, outs4, next_outs4;
  logic [7:0] next_outs8;
  logic hit_mixed, hit_out, do_clear;

  // Address match against the two bank addresses
  assign hit_mixed = shreg[7:1] == {`PXA_MIXED_HI, addr_s}; // [R1]
  assign hit_out = shreg[7:1] == {`PXA_OUT_HI, addr_s}; // [R1]

  // Next state of protocol, snapshot, flags and alert
  always_comb begin
    next_st = st;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_is_read = is_read;
    next_to_mixed = to_mixed;
    next_byte_sel = byte_sel;
    next_in_read = in_read;
    next_sda_oe_n = sda_oe_n;
    next_snap_flags = snap_flags;
    next_irq_mask = irq_mask;
    next_outs4 = outs4;
    next_outs8 = output_bank_pins;
    next_ref_in = ref_in;
    do_clear = 1'b0;
    // Sticky change flags, any input, mask ignored
    next_flags = flags | (sense_s ^ ref_in); // [R16] [R17]
    // Masked flag while reading waits for STOP
    next_pending = in_read & |(flags & irq_mask); // [R18] [R20]
    next_alert_oe_n = in_read ? alert_oe_n
                      : alert_oe_n & ~|(flags & irq_mask); // [R6]
    case (st)
      st_idle: ;
      st_addr: begin
        if (scl_rise) begin
          next_shreg = {shreg[6:0], sda_s};
          next_bit_cnt = bit_cnt + 4'h1;
        end else if (scl_fall && bit_cnt == `PXA_BYTE_BITS) begin
          if (hit_mixed || hit_out) begin
            next_sda_oe_n = 1'b0; // [R1]
            next_st = st_addr_ack;
            next_is_read = shreg[0];
            next_to_mixed = hit_mixed;
          end else begin
            next_st = st_idle;
          end
        end
      end
      st_addr_ack: begin
        if (scl_rise) begin
          if (to_mixed) begin
            // Address acknowledge clears flags and alert
            do_clear = 1'b1; // [R2] [R8] [R14]
            next_in_read = is_read;
            next_byte_sel = 1'b1;
            next_snap_flags = next_flags; // [R4]
            next_shreg = build_mixed(mixrb_s, sense_s); // [R2] [R7]
          end else begin
            next_shreg = outrb_s; // [R3] [R7]
          end
        end else if (scl_fall) begin
          next_bit_cnt = 4'h0;
          next_sda_oe_n = is_read ? shreg[7] : 1'b1;
          next_st = is_read ? st_rdata : st_wdata;
        end
      end
      st_rdata: begin
        if (scl_rise) begin
          next_bit_cnt = bit_cnt + 4'h1;
        end else if (scl_fall) begin
          if (bit_cnt == `PXA_BYTE_BITS) begin
            next_sda_oe_n = 1'b1;
            next_st = st_rack;
          end else begin
            next_sda_oe_n = shreg[6];
            next_shreg = {shreg[6:0], 1'b0};
          end
        end
      end
      st_rack: begin
        if (scl_rise && sda_s) begin
          next_st = st_idle; // [R11]
        end else if (scl_rise) begin
          next_bit_cnt = 4'h0;
          if (!to_mixed) begin
            next_shreg = outrb_s; // [R13]
          end else if (byte_sel) begin
            next_shreg = build_mixed(4'h0, snap_flags); // [R4]
            next_byte_sel = 1'b0;
          end else begin
            // New pair: resample and restart detection
            do_clear = 1'b1; // [R5] [R15]
            next_snap_flags = next_flags;
            next_byte_sel = 1'b1;
            next_shreg = build_mixed(mixrb_s, sense_s); // [R5] [R7]
          end
        end else if (scl_fall && bit_cnt == 4'h0) begin
          next_sda_oe_n = shreg[7];
          next_st = st_rdata;
        end
      end
      st_wdata: begin
        if (scl_rise) begin
          next_shreg = {shreg[6:0], sda_s};
          next_bit_cnt = bit_cnt + 4'h1;
        end else if (scl_fall && bit_cnt == `PXA_BYTE_BITS) begin
          next_sda_oe_n = 1'b0; // [R9] [R10]
          next_st = st_wack;
        end
      end
      st_wack: begin
        if (scl_rise) begin
          if (to_mixed) begin
            next_outs4 = {shreg[7], shreg[6], shreg[1], shreg[0]}; // [R8]
            next_irq_mask = shreg[5:2]; // [R8] [R9] [R19]
          end else begin
            next_outs8 = shreg; // [R10]
          end
        end else if (scl_fall) begin
          next_sda_oe_n = 1'b1;
          next_bit_cnt = 4'h0;
          next_st = st_wdata;
        end
      end
      default: next_st = st_idle;
    endcase
    if (do_clear) begin
      // Detection restarts from the sampled inputs
      next_flags = 4'h0; // [R15]
      next_ref_in = sense_s;
      next_pending = 1'b0;
      next_alert_oe_n = 1'b1; // [R12]
    end
    if (stop_det) begin
      next_st = st_idle;
      next_sda_oe_n = 1'b1;
      next_in_read = 1'b0;
      next_alert_oe_n = alert_oe_n & ~pending; // [R6] [R20]
    end else if (start_det) begin
      next_st = st_addr;
      next_bit_cnt = 4'h0;
      next_sda_oe_n = 1'b1;
    end
  end

  // Registers of the access logic
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= st_idle;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      is_read <= 1'b0;
      to_mixed <= 1'b0;
      byte_sel <= 1'b0;
      in_read <= 1'b0;
      pending <= 1'b0;
      sda_oe_n <= 1'b1;
      alert_oe_n <= 1'b1;
      sda_out <= 1'b0;
      alert_out <= 1'b0;
      flags <= 4'h0;
      ref_in <= 4'h0;
      snap_flags <= 4'h0;
      irq_mask <= `PXA_MASK_RST;
      outs4 <= `PXA_OUT4_RST;
      output_bank_pins <= `PXA_OUT8_RST;
    end else begin
      st <= next_st;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      is_read <= next_is_read;
      to_mixed <= next_to_mixed;
      byte_sel <= next_byte_sel;
      in_read <= next_in_read;
      pending <= next_pending;
      sda_oe_n <= next_sda_oe_n;
      alert_oe_n <= next_alert_oe_n;
      sda_out <= 1'b0;
      alert_out <= 1'b0;
      flags <= next_flags;
      ref_in <= next_ref_in;
      snap_flags <= next_snap_flags;
      irq_mask <= next_irq_mask;
      outs4 <= next_outs4;
      output_bank_pins <= next_outs8;
    end
  end

  // Mixed bank outputs at their pin positions
  assign {mixed_bank_out_7, mixed_bank_out_6} = outs4[3:2];
  assign {mixed_bank_out_1, mixed_bank_out_0} = outs4[1:0];

  // Checks on the access behaviour
  sequence seq_wack_mixed;
    st == st_wack && scl_rise && to_mixed && !stop_det && !start_det;
  endsequence
  sequence seq_read_stop;
    in_read && pending && stop_det;
  endsequence

  AST_ADDR_ACK: assert property (@(posedge clk) disable iff (!nrst) // [R1]
    (st == st_addr && scl_fall && bit_cnt == `PXA_BYTE_BITS && hit_mixed
     && !stop_det && !start_det) |=> !sda_oe_n && st == st_addr_ack)
    else $error("address not acknowledged");
  AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (!nrst) // [R2]
    (st == st_addr_ack && scl_rise && to_mixed) |=> flags == 4'h0
    ##0 alert_oe_n)
    else $error("flags or alert not cleared at address ack");
  AST_OUT_READBACK: assert property (@(posedge clk) disable iff (!nrst) // [R3]
    (!to_mixed && scl_rise && !stop_det && !start_det
     && (st == st_addr_ack || (st == st_rack && !sda_s)))
    |=> shreg == $past(outrb_s))
    else $error("output bank byte is not pin readback");
  AST_FLAG_BYTE: assert property (@(posedge clk) disable iff (!nrst) // [R4]
    (st == st_rack && scl_rise && !sda_s && to_mixed && byte_sel
     && !stop_det && !start_det)
    |=> shreg == build_mixed(4'h0, $past(snap_flags)))
    else $error("second byte not the captured flags");
  AST_ALERT_HOLD: assert property (@(posedge clk) disable iff (!nrst) // [R12]
    (in_read && alert_oe_n && !stop_det) |=> alert_oe_n)
    else $error("alert asserted during a read");
  AST_WRITE_MIXED: assert property (@(posedge clk) disable iff (!nrst) // [R9]
    seq_wack_mixed |=> irq_mask == $past(shreg[5:2])
    && outs4 == {$past(shreg[7]), $past(shreg[6]), $past(shreg[1]),
                 $past(shreg[0])})
    else $error("mixed write not applied");
  AST_WRITE_OUT: assert property (@(posedge clk) disable iff (!nrst) // [R10]
    (st == st_wack && scl_rise && !to_mixed)
    |=> output_bank_pins == $past(shreg))
    else $error("output bank write not applied");
  AST_NACK: assert property (@(posedge clk) disable iff (!nrst) // [R11]
    (st == st_rack && scl_rise && sda_s && !stop_det)
    |=> st == st_idle && $stable(alert_oe_n) && $stable(snap_flags))
    else $error("no-acknowledge changed snapshot or alert");
  AST_STOP_ALERT: assert property (@(posedge clk) disable iff (!nrst) // [R20]
    seq_read_stop |=> !alert_oe_n ##1 !alert_oe_n)
    else $error("deferred alert not raised at stop");
  AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!nrst) // [R17]
    (flags != 4'h0 && !do_clear) |=> (flags & $past(flags)) == $past(flags))
    else $error("transition flag lost without access");
  AST_FLAG_SET: assert property (@(posedge clk) disable iff (!nrst) // [R16]
    (sense_s != ref_in && !do_clear) |=> (flags & $past(sense_s ^ ref_in))
    == $past(sense_s ^ ref_in))
    else $error("input change not flagged");
endmodule // pxa_access

// ===== logic/pxa_defs.svh
// Constants of the port expander serial access block.
// Assumes a 7-bit two-wire target address, bus sampled by the system clock.
// Behaviour
// [R1] Answer two addresses: mixed bank, output bank
// [R2] Mixed one-byte read: inputs plus readback
// [R3] Output bank read returns actual pin levels
// [R4] Second mixed byte carries flags before clear
// [R5] Long mixed read alternates, resamples per pair
// [R6] Alert change during read deferred to STOP
// [R7] Capture data at acknowledge preceding each byte
// [R8] Mixed write sets outputs and interrupt mask
// [R9] Mixed write updates on every acknowledged byte
// [R10] Output bank write loads eight outputs per byte
// [R11] Master no-acknowledge: no snapshot, alert unchanged
// [R12] Alert stays released until STOP after read
// [R13] Output bank resampled at every acknowledge
// [R14] STOP after address still clears flags
// [R15] Detection restarts from transmitted snapshot
// [R16] Flags set on any change, mask ignored
// [R17] Flags stay set until serial access
// [R18] No alert at STOP for transmitted changes
// [R19] Byte bit n maps to port n
// [R20] Deferred alert kept as pending flag
`ifndef PXA_DEFS_SVH
`define PXA_DEFS_SVH
`define PXA_MIXED_HI 3'h6
`define PXA_OUT_HI 3'h5
`define PXA_BYTE_BITS 4'h8
`define PXA_MASK_RST 4'h0
`define PXA_OUT4_RST 4'h0
`define PXA_OUT8_RST 8'h00
`endif

// ===== logic/pxa_pkg.sv
// Types of the port expander serial access block.
// Assumes the constants header is included by the design file.
package pxa_pkg;
  typedef enum logic [2:0] {
    st_idle, st_addr, st_addr_ack, st_rdata, st_rack, st_wdata, st_wack
  } pxa_state_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } pxa_bus_t;
endpackage

// ===== test/pxa_master.sv
// Bus master model driving the expander's two-wire target port.
// Assumes a 50 MHz clk; one bit takes 8 clk, a 160 ns link clock.
module pxa_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  output logic got,
  output logic [7:0] rx
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    got = 1'b0;
    rx = 8'h00;
  end
  // Wait on falling edges of clk
  task automatic tk(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One bit, data only changes while the clock is low
  task automatic bit_io(input logic b, output logic s);
    tk(2);
    sda_low = ~b;
    tk(2);
    scl = 1'b1;
    tk(4);
    s = sda;
    scl = 1'b0;
  endtask
  // Data falls with the clock high
  task automatic start();
    sda_low = 1'b0;
    tk(2);
    scl = 1'b1;
    tk(4);
    sda_low = 1'b1;
    tk(4);
    scl = 1'b0;
  endtask
  // Data rises with the clock high, bus left idle
  task automatic stop();
    tk(2);
    sda_low = 1'b1;
    tk(2);
    scl = 1'b1;
    tk(4);
    sda_low = 1'b0;
    tk(4);
  endtask
  // Byte out MSB first, then the target's ack bit
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, ack);
  endtask
  // Byte in MSB first, strobe it, then our ack or no-ack
  task automatic rbyte(input logic nak);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    rx = d;
    got = 1'b1;
    tk(1);
    got = 1'b0;
    bit_io(nak, s);
  endtask
endmodule // pxa_master

// ===== test/tb.sv
// Self-checking bench for the expander access block and a bus master.
// Assumes the design files and pxa_master.sv are compiled before it.
`include "pxa_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, scl, sda_low, got, ack, sda_out, sda_oe_n;
  logic o0, o1, o6, o7, alert_out, alert_oe_n;
  logic [3:0] addr_low, sin, mos, msk, v;
  logic [7:0] obs, obp, rx, b;
  logic [7:0] expq[$];
  int n_mismatch = 0;
  int checks = 0;
  // Open-drain data line with pull-up
  wire sda = ~(sda_low | ~sda_oe_n);
  pxa_access pxa_access_i (.clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_low(addr_low),
    .sense_inputs(sin), .mixed_out_sense(mos), .output_bank_sense(obs),
    .mixed_bank_out_0(o0), .mixed_bank_out_1(o1), .mixed_bank_out_6(o6),
    .mixed_bank_out_7(o7), .output_bank_pins(obp), .irq_mask(msk),
    .alert_out(alert_out), .alert_oe_n(alert_oe_n));
  pxa_master pxa_master_i (.clk(clk), .sda(sda), .scl(scl),
    .sda_low(sda_low), .got(got), .rx(rx));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Compare one value, count and report
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Each received byte against the oldest note
  always @(posedge clk) begin
    if (got === 1'b1) begin
      cmp(rx, expq.pop_front());
    end
  end
  // Mixed port byte from the levels the bench drives
  function automatic logic [7:0] pb();
    return {mos[3], mos[2], sin, mos[1], mos[0]};
  endfunction
  task automatic open(input logic [2:0] hi, input logic rw, input logic e);
    pxa_master_i.start();
    pxa_master_i.wbyte({hi, addr_low, rw}, ack);
    cmp({7'h00, ack}, {7'h00, e});
  endtask
  task automatic wr(input logic [7:0] d);
    pxa_master_i.wbyte(d, ack);
    pxa_master_i.tk(3);
    cmp({7'h00, ack}, 8'h00);
  endtask
  task automatic alert(input logic e);
    pxa_master_i.tk(6);
    cmp({7'h00, alert_oe_n}, {7'h00, e});
  endtask
  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Cut a hang short
  initial begin
    #300us;
    n_mismatch++;
    complete_run();
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    addr_low = 4'h0;
    sin = 4'h0;
    mos = 4'h0;
    obs = 8'h00;
    v = 4'h0;
    b = 8'($urandom(32'h6d6d));
    addr_low = b[3:0];
    mos = b[7:4];
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    cmp({o7, o6, msk, o1, o0}, 8'h00);
    // Mixed write, two bytes, the last one sets the full mask
    open(`PXA_MIXED_HI, 1'b0, 1'b0);
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      if (i == 1) b[5:2] = 4'hf;
      wr(b);
      cmp({o7, o6, msk, o1, o0}, b);
    end
    pxa_master_i.stop();
    // Output bank write, two bytes
    open(`PXA_OUT_HI, 1'b0, 1'b0);
    repeat (2) begin
      b = 8'($urandom);
      wr(b);
      cmp(obp, b);
    end
    pxa_master_i.stop();
    // Foreign address is left unanswered
    open(3'h7, 1'b0, 1'b1);
    pxa_master_i.stop();
    // Pulse on random ports sets flags that survive the return
    v = 4'($urandom) | 4'h1;
    sin = v;
    alert(1'b0);
    sin = 4'h0;
    alert(1'b0);
    // Long mixed read, change inside the first pair
    expq.push_back(pb());
    expq.push_back({2'b00, v, 2'b00});
    open(`PXA_MIXED_HI, 1'b1, 1'b0);
    alert(1'b1);
    pxa_master_i.rbyte(1'b0);
    v = 4'($urandom) | 4'h2;
    sin = v;
    mos = 4'($urandom);
    expq.push_back(pb());
    expq.push_back({2'b00, v, 2'b00});
    pxa_master_i.rbyte(1'b0);
    alert(1'b1);
    pxa_master_i.rbyte(1'b0);
    pxa_master_i.rbyte(1'b1);
    pxa_master_i.stop();
    alert(1'b1);
    // Output bank read shows pin levels, fresh at every ack
    obs = ~obp;
    expq.push_back(obs);
    open(`PXA_OUT_HI, 1'b1, 1'b0);
    obs = 8'($urandom);
    expq.push_back(obs);
    pxa_master_i.rbyte(1'b0);
    pxa_master_i.rbyte(1'b1);
    pxa_master_i.stop();
    // New address; change after the snapshot alerts only at stop
    addr_low = 4'($urandom);
    expq.push_back(pb());
    open(`PXA_MIXED_HI, 1'b1, 1'b0);
    pxa_master_i.tk(2);
    v = 4'($urandom) | 4'h1;
    sin = sin ^ v;
    pxa_master_i.rbyte(1'b1);
    alert(1'b1);
    pxa_master_i.stop();
    alert(1'b0);
    // Address then stop still clears the flags
    open(`PXA_MIXED_HI, 1'b0, 1'b0);
    pxa_master_i.stop();
    alert(1'b1);
    expq.push_back(pb());
    expq.push_back(8'h00);
    open(`PXA_MIXED_HI, 1'b1, 1'b0);
    pxa_master_i.rbyte(1'b0);
    pxa_master_i.rbyte(1'b1);
    pxa_master_i.stop();
    // Mask cleared: a change still sets its flag, alert stays off
    b = 8'($urandom);
    b[5:2] = 4'h0;
    open(`PXA_MIXED_HI, 1'b0, 1'b0);
    wr(b);
    cmp({o7, o6, msk, o1, o0}, b);
    pxa_master_i.stop();
    v = 4'($urandom) | 4'h8;
    sin = sin ^ v;
    alert(1'b1);
    expq.push_back(pb());
    expq.push_back({2'b00, v, 2'b00});
    open(`PXA_MIXED_HI, 1'b1, 1'b0);
    pxa_master_i.rbyte(1'b0);
    pxa_master_i.rbyte(1'b1);
    pxa_master_i.stop();
    // Open-drain value pins never drive high
    cmp({6'h00, sda_out, alert_out}, 8'h00);
    complete_run();
  end
endmodule // tb
